//--- rtl/ccs_defs.svh
// Purpose: Constants for the charge cycle sequencer
// Assumes: 10 MHz clock
// Notes:   Currents are codes of 50 mA; times are seconds
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

`define CCS_CLK_HZ        10000000
`define CCS_SEC_S         1
`define CCS_SEC_CYC       (`CCS_SEC_S * `CCS_CLK_HZ)
`define CCS_FB_TARGET_MV  1536
`define CCS_BLOW_DEF      2'h2
`define CCS_RECHG_DEF     2'h3
`define CCS_CVT_DEF       3'h0
`define CCS_SAFETY_S      16'hA8C0
`define CCS_CV_STEP_S     16'h0384
`define CCS_TOP_STEP_S    16'h012C
`define CCS_ILIM_MIN      9'h008
`define CCS_ILIM_MAX      9'h190
`define CCS_PRE_DIV       9'h005
`define CCS_TERM_DIV      9'h00A
`define CCS_PH_IDLE       3'h0
`define CCS_PH_TRICKLE    3'h1
`define CCS_PH_PRECHG     3'h2
`define CCS_PH_CC         3'h3
`define CCS_PH_CV         3'h4
`define CCS_PH_TOPOFF     3'h6
`define CCS_PH_DONE       3'h7

`endif

//--- rtl/ccs_pkg.sv
// Purpose: Types for the charge cycle sequencer
// Assumes: Nothing
// Notes:   Constants live in ccs_defs.svh
package ccs_pkg;

    typedef enum logic [2:0] {
        CCS_IDLE,
        CCS_TRICKLE,
        CCS_PRECHG,
        CCS_CC,
        CCS_CV,
        CCS_TOPOFF,
        CCS_DONE
    } ccs_state_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic        odd;
        logic        done;
    } ccs_tmr_s;

    typedef struct packed {
        logic [19:0] s1;
        logic [19:0] s2;
        ccs_state_e  st;
        logic [2:0]  phase;
        logic        intp;
        logic        fault;
        logic        pin_stby;
        logic        stby;
        logic        sw_en;
        logic        bias_en;
        logic        pin_mon;
        logic [8:0]  lim;
        logic [8:0]  pre;
        logic [8:0]  term;
        logic [23:0] sec_cnt;
        logic        tick;
    } ccs_main_s;

endpackage

//--- rtl/ccs_timer.sv
// Purpose: Seconds timer with half-rate option and sticky expiry
// Assumes: tick is a one-cycle pulse once per second
// Notes:   A limit of zero keeps the timer idle
module ccs_timer (
    input  wire logic        clk,    // Clock
    input  wire logic        rst,    // Sync reset
    input  wire logic        ce,     // Clock enable
    input  wire logic        clear,  // Restart from zero
    input  wire logic        run,    // Count while high
    input  wire logic        half,   // Count every other tick
    input  wire logic        tick,   // Seconds pulse
    input  wire logic [15:0] limit,  // Period in seconds
    output logic             done    // Expired, sticky
);
    ccs_pkg::ccs_tmr_s q;
    ccs_pkg::ccs_tmr_s n;

    always_comb
    begin
        n = q;
        if (clear)
        begin
            n = '0;
        end
        else if (run && tick && !q.done && limit != 16'h0000)
        begin
            if (half && !q.odd)
            begin
                n.odd = 1'b1;
            end
            else
            begin
                n.odd = 1'b0;
                n.cnt = q.cnt + 16'h0001;
                n.done = (q.cnt == limit - 16'h0001);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else if (ce)
            q <= n;
    end

    assign done = q.done;
endmodule

//--- rtl/ccs_top.sv
// Purpose: Standby control and autonomous charge cycle sequencer
// Assumes: Config bits are host register outputs, synchronous to clk
// Notes:   Comparator and pin levels pass a two-flop synchroniser
//
// Functional notes
// - Force bit or standby pin high enters standby; switching and bias off.
// - Standby halts reverse switching; reverse resumes once standby clears.
// - Standby ends once force bit is clear and pin has fallen below 0.4 V.
// - Charging needs enable bit 1 and enable pin low; cycle runs alone.
// - Cycle start picks phase from battery level; then trickle to top-off.
// - Feedback regulation target defaults to 1.536 V.
// - Defaults: low 66.7%, recharge 97.6%, CV timer off, safety 12 hours.
// - Effective limit gives pre-charge 20% and termination 10% thresholds.
// - Start needs input window, no standby, bias good, enabled, no faults.
// - Terminate when current low, battery above recharge, no input regulation.
// - After termination, battery below selected recharge level restarts cycle.
// - Toggling enable pin or bit after completion restarts the cycle.
// - CV timer ends charging after its period regardless of current.
// - Phase code map 000 idle through 111 terminated, 101 reserved.
// - Every phase code change issues one interrupt pulse.
// - Pre-charge disabled skips trickle and pre-charge, full current.
// - Effective limit is the lower of pin and register limits.
// - Pin enable 0 ignores pin for limiting and monitoring.
// - Register limit 400 to 20000 mA in 50 mA steps, reset maximum.
// - Input regulation suspends termination and halves safety timer rate.
// - Safety timer expiry sets fault flag and pulses interrupt.
// - CV period 0 disables CV timer; half rate never applies.
`include "ccs_defs.svh"

module ccs_top #(
    parameter int SEC_CYCLES = `CCS_SEC_CYC  // Cycles per second tick
) (
    input  wire logic       clk,                            // Clock 10 MHz
    input  wire logic       rst,                            // Sync reset
    input  wire logic       ce,                             // Clock enable
    input  wire logic       force_standby_bit,              // Host standby
    input  wire logic       input_limit_standby_pin,        // Pin above high level
    input  wire logic       standby_pin_low,                // Pin below 0.4 V
    input  wire logic       reverse_mode_enable,            // Reverse converter on
    input  wire logic       charge_enable_bit,              // Host enable
    input  wire logic       charge_enable_pin_n,            // Enable pin, low on
    input  wire logic       precharge_enable_bit,           // Trickle/pre phases
    input  wire logic       termination_enable_bit,         // Termination on
    input  wire logic       safety_timer_enable_bit,        // Safety timer on
    input  wire logic       timer_half_rate_enable_bit,     // Half rate allowed
    input  wire logic       current_pin_enable_bit,         // Use current pin
    input  wire logic [8:0] charge_current_pin,             // Pin limit code
    input  wire logic [8:0] charge_current_limit_field,     // Register limit code
    input  wire logic [1:0] recharge_threshold_select,      // Recharge level
    input  wire logic [1:0] battery_low_threshold_select,   // Low level
    input  wire logic [2:0] constant_voltage_timer_period,  // CV period code
    input  wire logic [1:0] topoff_timer_period,            // Top-off code
    input  wire logic       input_undervoltage_sense,       // Input under window
    input  wire logic       input_overvoltage_sense,        // Input over window
    input  wire logic       bias_regulator_good,            // Bias rail good
    input  wire logic       thermistor_input,               // Thermistor fault
    input  wire logic       fb_below_short,                 // Below short level
    input  wire logic [3:0] fb_below_low_levels,            // Below low, per code
    input  wire logic [3:0] fb_above_recharge_levels,       // Above recharge
    input  wire logic       fb_below_target,                // Below target
    input  wire logic       cv_regulation,                  // Voltage loop active
    input  wire logic       current_below_term,             // Below termination
    input  wire logic       input_power_regulation,         // Input regulating
    output logic [2:0]      phase_code,                     // Charge phase
    output logic            int_pulse,                      // Host interrupt
    output logic            safety_timer_fault_flag,        // Safety expired
    output logic            standby_active,                 // In standby
    output logic            switching_enable,               // Converter runs
    output logic            bias_regulator_enable,          // Bias rail on
    output logic            pin_monitor_enable,             // Pin monitor on
    output logic [8:0]      effective_limit,                // Charge limit
    output logic [8:0]      precharge_limit,                // Pre-charge limit
    output logic [8:0]      termination_threshold           // Termination level
);
    ccs_pkg::ccs_main_s q;
    ccs_pkg::ccs_main_s n;

    logic       pin_hi;
    logic       pin_lo;
    logic       en_n;
    logic       uv;
    logic       ov;
    logic       bias_ok;
    logic       therm;
    logic       short_s;
    logic [3:0] low_v;
    logic [3:0] rechg_v;
    logic       tgt_s;
    logic       cvr_s;
    logic       lowi_s;
    logic       ipr_s;
    logic       chg_en;
    logic       start_ok;
    logic       charging;
    logic       low_s;
    logic       above_rechg;
    logic       term_ok;
    logic       half;
    logic       saf_done;
    logic       cvt_done;
    logic       top_done;
    logic [15:0] cv_lim;
    logic [15:0] top_lim;
    logic [8:0] reg_lim;

    assign {pin_hi, pin_lo, en_n, uv, ov, bias_ok, therm, short_s,
            low_v, rechg_v, tgt_s, cvr_s, lowi_s, ipr_s} = q.s2;

    assign chg_en = charge_enable_bit && !en_n;
    assign start_ok = !uv && !ov && !q.stby && bias_ok && chg_en
                      && !therm && !q.fault;
    assign charging = q.st != ccs_pkg::CCS_IDLE && q.st != ccs_pkg::CCS_DONE;
    assign low_s = low_v[battery_low_threshold_select];
    assign above_rechg = rechg_v[recharge_threshold_select];
    // Input regulation blocks termination
    assign term_ok = termination_enable_bit && lowi_s && above_rechg && !ipr_s;
    assign half = timer_half_rate_enable_bit && ipr_s;
    assign cv_lim = 16'(constant_voltage_timer_period) * `CCS_CV_STEP_S;
    assign top_lim = 16'(topoff_timer_period) * `CCS_TOP_STEP_S;

    ccs_timer u_safety (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .clear (!chg_en || !safety_timer_enable_bit || q.st == ccs_pkg::CCS_DONE),
        .run   (charging),
        .half  (half),
        .tick  (q.tick),
        .limit (`CCS_SAFETY_S),
        .done  (saf_done)
    );

    // Absolute timer, counts only in CV and pauses while input regulation is active
    ccs_timer u_cv (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .clear (!chg_en || q.st == ccs_pkg::CCS_DONE),
        .run   (q.st == ccs_pkg::CCS_CV && !ipr_s),
        .half  (1'b0),
        .tick  (q.tick),
        .limit (cv_lim),
        .done  (cvt_done)
    );

    ccs_timer u_topoff (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .clear (q.st != ccs_pkg::CCS_TOPOFF),
        .run   (1'b1),
        .half  (half),
        .tick  (q.tick),
        .limit (top_lim),
        .done  (top_done)
    );

    function automatic ccs_pkg::ccs_state_e entry(input logic pre_en, input logic sh, input logic lo);
        if (!pre_en)
            entry = ccs_pkg::CCS_CC;
        else if (sh)
            entry = ccs_pkg::CCS_TRICKLE;
        else if (lo)
            entry = ccs_pkg::CCS_PRECHG;
        else
            entry = ccs_pkg::CCS_CC;
    endfunction

    function automatic logic [2:0] code_of(input ccs_pkg::ccs_state_e s);
        unique case (s)
            ccs_pkg::CCS_IDLE:    code_of = `CCS_PH_IDLE;
            ccs_pkg::CCS_TRICKLE: code_of = `CCS_PH_TRICKLE;
            ccs_pkg::CCS_PRECHG:  code_of = `CCS_PH_PRECHG;
            ccs_pkg::CCS_CC:      code_of = `CCS_PH_CC;
            ccs_pkg::CCS_CV:      code_of = `CCS_PH_CV;
            ccs_pkg::CCS_TOPOFF:  code_of = `CCS_PH_TOPOFF;
            ccs_pkg::CCS_DONE:    code_of = `CCS_PH_DONE;
            default:              code_of = `CCS_PH_IDLE;
        endcase
    endfunction

    always_comb
    begin
        n = q;
        n.s1 = {input_limit_standby_pin, standby_pin_low, charge_enable_pin_n,
                input_undervoltage_sense, input_overvoltage_sense, bias_regulator_good,
                thermistor_input, fb_below_short, fb_below_low_levels,
                fb_above_recharge_levels, fb_below_target, cv_regulation,
                current_below_term, input_power_regulation};
        n.s2 = q.s1;
        n.tick = (q.sec_cnt == 24'(SEC_CYCLES - 1));
        n.sec_cnt = n.tick ? 24'h000000 : q.sec_cnt + 24'h000001;

        // Pin side keeps hysteresis: set above high level, free below 0.4 V
        if (pin_hi)
            n.pin_stby = 1'b1;
        else if (pin_lo)
            n.pin_stby = 1'b0;
        n.stby = force_standby_bit || n.pin_stby;

        unique case (q.st)
            ccs_pkg::CCS_IDLE:
                if (start_ok)
                    n.st = entry(precharge_enable_bit, short_s, low_s);
            ccs_pkg::CCS_TRICKLE:
                if (!precharge_enable_bit || !short_s)
                    n.st = (precharge_enable_bit && low_s) ? ccs_pkg::CCS_PRECHG : ccs_pkg::CCS_CC;
            ccs_pkg::CCS_PRECHG:
                if (!precharge_enable_bit || !low_s)
                    n.st = ccs_pkg::CCS_CC;
            ccs_pkg::CCS_CC:
                if (cvr_s || !tgt_s)
                    n.st = ccs_pkg::CCS_CV;
            ccs_pkg::CCS_CV:
                if (cvt_done)
                    n.st = ccs_pkg::CCS_DONE;
                else if (term_ok)
                    n.st = (top_lim != 16'h0000) ? ccs_pkg::CCS_TOPOFF : ccs_pkg::CCS_DONE;
            ccs_pkg::CCS_TOPOFF:
                if (top_done)
                    n.st = ccs_pkg::CCS_DONE;
            ccs_pkg::CCS_DONE:
                if (!above_rechg && start_ok)
                    n.st = entry(precharge_enable_bit, short_s, low_s);
            default:
                n.st = ccs_pkg::CCS_IDLE;
        endcase
        if (charging && (!start_ok || saf_done))
            n.st = ccs_pkg::CCS_IDLE;
        // Dropping enable ends the cycle; re-enable starts a fresh one
        if (!chg_en)
            n.st = ccs_pkg::CCS_IDLE;

        // Clear first so a same-cycle expiry still sets
        if (!chg_en)
            n.fault = 1'b0;
        if (charging && saf_done)
            n.fault = 1'b1;

        n.phase = code_of(n.st);
        n.intp = (n.phase != q.phase) || (n.fault && !q.fault);

        // Reverse conversion holds its request through standby
        n.sw_en = !n.stby && ((n.st != ccs_pkg::CCS_IDLE && n.st != ccs_pkg::CCS_DONE)
                  || reverse_mode_enable);
        n.bias_en = !n.stby && ((!uv && !ov && chg_en) || reverse_mode_enable);

        reg_lim = charge_current_limit_field;
        if (reg_lim < `CCS_ILIM_MIN)
            reg_lim = `CCS_ILIM_MIN;
        else if (reg_lim > `CCS_ILIM_MAX)
            reg_lim = `CCS_ILIM_MAX;
        n.lim = (current_pin_enable_bit && charge_current_pin < reg_lim)
                ? charge_current_pin : reg_lim;
        n.pre = n.lim / `CCS_PRE_DIV;
        n.term = n.lim / `CCS_TERM_DIV;
        n.pin_mon = current_pin_enable_bit;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else if (ce)
            q <= n;
    end

    assign phase_code = q.phase;
    assign int_pulse = q.intp;
    assign safety_timer_fault_flag = q.fault;
    assign standby_active = q.stby;
    assign switching_enable = q.sw_en;
    assign bias_regulator_enable = q.bias_en;
    assign pin_monitor_enable = q.pin_mon;
    assign effective_limit = q.lim;
    assign precharge_limit = q.pre;
    assign termination_threshold = q.term;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_stby_off;
        standby_active |-> !bias_regulator_enable && !switching_enable;
    endproperty
    a_stby_off: assert property (p_stby_off) else $error("output on in standby");
    property p_force;
        ce && force_standby_bit |=> standby_active;
    endproperty
    a_force: assert property (p_force) else $error("force bit missed");
    property p_reset_idle;
        $past(rst) |-> phase_code == 3'h0 && !int_pulse;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("phase not idle after reset");
    property p_int;
        phase_code != $past(phase_code) |-> int_pulse;
    endproperty
    a_int: assert property (p_int) else $error("phase change without interrupt");
    property p_limit;
        ce && current_pin_enable_bit |=> effective_limit <= $past(charge_current_pin)
            && effective_limit <= `CCS_ILIM_MAX;
    endproperty
    a_limit: assert property (p_limit) else $error("limit above pin");
    property p_pin_off;
        ce && !current_pin_enable_bit && charge_current_limit_field == 9'h0C8
            |=> effective_limit == 9'h0C8 && !pin_monitor_enable;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin not ignored");
    property p_nostart;
        ce && q.st == ccs_pkg::CCS_IDLE && !start_ok |=> phase_code == 3'h0;
    endproperty
    a_nostart: assert property (p_nostart) else $error("start without conditions");
    property p_skip_pre;
        ce && q.st == ccs_pkg::CCS_IDLE && start_ok && !precharge_enable_bit
            |=> phase_code == 3'h3 ##1 int_pulse == 1'b0 || phase_code != 3'h3;
    endproperty
    a_skip_pre: assert property (p_skip_pre) else $error("precharge not skipped");
    property p_fault;
        ce && charging && saf_done && chg_en |=> safety_timer_fault_flag && int_pulse;
    endproperty
    a_fault: assert property (p_fault) else $error("safety expiry not flagged");
    property p_term;
        ce && chg_en && start_ok && !saf_done && q.st == ccs_pkg::CCS_CV && !cvt_done
            && term_ok && topoff_timer_period == 2'h0 |=> phase_code == 3'h7 && int_pulse;
    endproperty
    a_term: assert property (p_term) else $error("termination missed");
    property p_disable;
        ce && !chg_en |=> phase_code == 3'h0 ##1 !ce || phase_code == 3'h0 || chg_en;
    endproperty
    a_disable: assert property (p_disable) else $error("runs while disabled");

    c_cv: cover property (phase_code == 3'h4);
    c_done: cover property (phase_code == 3'h7 ##[1:1000] phase_code == 3'h3);
    c_fault: cover property ($rose(safety_timer_fault_flag));
endmodule

//--- tb/ccs_host_model.sv
// Purpose: Host model that owns the charger configuration bits
// Assumes: Bench calls wr just after a rising edge
// Notes:   No bus timing; a write lands as a plain register update
module ccs_host_model (
    input  wire logic       clk,   // Clock
    input  wire logic       rst,   // Sync reset
    output logic            fsb,   // Force standby
    output logic            cen,   // Charge enable
    output logic            pen,   // Pre-charge enable
    output logic            ten,   // Termination enable
    output logic            sen,   // Safety timer enable
    output logic            hen,   // Half rate enable
    output logic            ipe,   // Current pin enable
    output logic [8:0]      lim,   // Register limit code
    output logic [1:0]      rsel,  // Recharge select
    output logic [1:0]      lsel,  // Battery low select
    output logic [2:0]      cvp,   // CV period code
    output logic [1:0]      top    // Top-off code
);
    task automatic dflt;
        fsb <= 1'h0;
        cen <= 1'h1;
        pen <= 1'h1;
        ten <= 1'h1;
        sen <= 1'h1;
        hen <= 1'h1;
        ipe <= 1'h1;
        lim <= 9'h190;
        rsel <= 2'h3;
        lsel <= 2'h2;
        cvp <= 3'h0;
        top <= 2'h0;
    endtask

    task automatic wr(input int k, input logic [8:0] v);
        case (k)
            0: fsb <= v[0];
            1: cen <= v[0];
            2: pen <= v[0];
            3: ten <= v[0];
            4: sen <= v[0];
            6: ipe <= v[0];
            7: lim <= v;
            8: rsel <= v[1:0];
            9: lsel <= v[1:0];
            10: cvp <= v[2:0];
            default: top <= v[1:0];
        endcase
    endtask

    initial dflt();

    always @(posedge clk)
        if (rst)
            dflt();
endmodule

//--- tb/tb_ccs_top.sv
// Purpose: Self-checking bench for the charge cycle sequencer
// Assumes: One-cycle seconds tick so the safety timer expires within the run
// Notes:   Inputs change on rising edges, outputs are sampled on falling ones
module tb_ccs_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEC = 1;
    logic       clk, rst, ce, stp, spl, rev, pin_n, sh, bt, cvr, cbt, ipr;
    logic       fsb, cen, pen, ten, sen, hen, ipe, ip, sf, sa, sw, be, pm;
    logic [1:0] rsel, lsel, top;
    logic [2:0] cvp, ph, prev;
    logic [3:0] flt, low, rch;
    logic [8:0] ipin, lim, el, pl, tt;
    logic [31:0] seed;
    int         n_errors, compares, nchg, npul;

    ccs_host_model host_i (.clk(clk), .rst(rst), .fsb(fsb), .cen(cen), .pen(pen), .ten(ten), .sen(sen),
        .hen(hen), .ipe(ipe), .lim(lim), .rsel(rsel), .lsel(lsel), .cvp(cvp), .top(top));

    ccs_top #(.SEC_CYCLES(SEC)) ccs_top_i (.clk(clk), .rst(rst), .ce(ce), .force_standby_bit(fsb),
        .input_limit_standby_pin(stp), .standby_pin_low(spl), .reverse_mode_enable(rev),
        .charge_enable_bit(cen), .charge_enable_pin_n(pin_n), .precharge_enable_bit(pen),
        .termination_enable_bit(ten), .safety_timer_enable_bit(sen), .timer_half_rate_enable_bit(hen),
        .current_pin_enable_bit(ipe), .charge_current_pin(ipin), .charge_current_limit_field(lim),
        .recharge_threshold_select(rsel), .battery_low_threshold_select(lsel),
        .constant_voltage_timer_period(cvp), .topoff_timer_period(top), .input_undervoltage_sense(flt[1]),
        .input_overvoltage_sense(flt[2]), .bias_regulator_good(!flt[3]), .thermistor_input(flt[0]),
        .fb_below_short(sh), .fb_below_low_levels(low), .fb_above_recharge_levels(rch),
        .fb_below_target(bt), .cv_regulation(cvr), .current_below_term(cbt), .input_power_regulation(ipr),
        .phase_code(ph), .int_pulse(ip), .safety_timer_fault_flag(sf), .standby_active(sa),
        .switching_enable(sw), .bias_regulator_enable(be), .pin_monitor_enable(pm), .effective_limit(el),
        .precharge_limit(pl), .termination_threshold(tt));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    function automatic logic [8:0] exp_lim(input logic en, input logic [8:0] p, input logic [8:0] f);
        logic [8:0] c;
        c = (f < 9'h008) ? 9'h008 : (f > 9'h190) ? 9'h190 : f;
        return (en && p < c) ? p : c;
    endfunction

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait, then the phase must have arrived
    task automatic wait_ph(input logic [2:0] p, input int lc);
        int i;
        i = 0;
        while (ph !== p && i < lc)
        begin
            @(negedge clk);
            i++;
        end
        chk({6'h00, ph}, {6'h00, p});
    endtask

    task automatic stop_test;
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // Every phase move must come with exactly one pulse cycle
    always @(negedge clk)
    begin
        if (!rst && ph !== prev)
            nchg++;
        if (!rst && ip === 1'h1)
            npul++;
        prev <= ph;
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        stop_test;
    end

    initial
    begin
        logic [8:0] f, p, e;
        logic       pe;
        rst = 1'h1;
        ce = 1'h1;
        {stp, spl, rev, sh, cvr, cbt, ipr} = 7'h00;
        pin_n = 1'h1;
        bt = 1'h1;
        flt = 4'h0;
        low = 4'h0;
        rch = 4'h0;
        ipin = 9'h0C8;
        prev = 3'h0;
        seed = 32'hF53D;
        cyc(4);
        chk({6'h00, ph}, 9'h000);
        chk(el, 9'h000);
        @(posedge clk);
        rst <= 1'h0;
        for (int k = 0; k < 24; k++)
        begin
            seed = xs(seed);
            f = (k == 0) ? 9'h008 : (k == 1) ? 9'h190 : (k == 2) ? 9'h0C8 : seed[24:16];
            p = 9'(seed[8:0] % 9'h1FF + 9'h001);
            pe = seed[9] && k != 2;
            e = exp_lim(pe, p, f);
            @(posedge clk);
            host_i.wr(6, {8'h00, pe});
            host_i.wr(7, f);
            ipin <= p;
            cyc(6);
            chk(el, e);
            chk({8'h00, pm}, {8'h00, pe});
            chk(pl, e / 9'h005);
            chk(tt, e / 9'h00A);
        end
        @(posedge clk);
        pin_n <= 1'h0;
        wait_ph(3'h3, 20);
        chk({8'h00, sw}, 9'h001);
        @(posedge clk);
        cvr <= 1'h1;
        wait_ph(3'h4, 20);
        @(posedge clk);
        {cbt, ipr} <= 2'h3;
        rch <= 4'hF;
        cyc(12);
        chk({6'h00, ph}, 9'h004);
        @(posedge clk);
        ipr <= 1'h0;
        wait_ph(3'h7, 20);
        @(posedge clk);
        {cvr, cbt} <= 2'h0;
        cyc(8);
        chk({6'h00, ph}, 9'h007);
        @(posedge clk);
        pin_n <= 1'h1;
        ce <= 1'h0;
        cyc(8);
        chk({6'h00, ph}, 9'h007);
        @(posedge clk);
        ce <= 1'h1;
        wait_ph(3'h0, 20);
        @(posedge clk);
        pin_n <= 1'h0;
        wait_ph(3'h3, 20);
        @(posedge clk);
        {cvr, cbt} <= 2'h3;
        wait_ph(3'h7, 30);
        @(posedge clk);
        host_i.wr(8, 9'h000);
        rch <= 4'h7;
        {cvr, cbt} <= 2'h0;
        cyc(8);
        chk({6'h00, ph}, 9'h007);
        @(posedge clk);
        host_i.wr(8, 9'h003);
        host_i.wr(9, 9'h003);
        wait_ph(3'h3, 20);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            pin_n <= 1'h1;
            cyc(6);
            @(posedge clk);
            sh <= (k != 1);
            low <= 4'hC;
            host_i.wr(2, {8'h00, k != 2});
            host_i.wr(3, {8'h00, k != 2});
            pin_n <= 1'h0;
            wait_ph((k == 0) ? 3'h1 : (k == 1) ? 3'h2 : 3'h3, 20);
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            pin_n <= 1'h1;
            cyc(6);
            @(posedge clk);
            flt <= 4'h1 << k;
            pin_n <= 1'h0;
            cyc(10);
            chk({6'h00, ph}, 9'h000);
        end
        @(posedge clk);
        {flt, low, sh, cbt} <= 10'h000;
        host_i.wr(2, 9'h001);
        host_i.wr(10, 9'h001);
        cvr <= 1'h1;
        wait_ph(3'h4, 30);
        cyc(800);
        chk({6'h00, ph}, 9'h004);
        wait_ph(3'h7, 1000);
        @(posedge clk);
        host_i.wr(0, 9'h001);
        cyc(2);
        chk({7'h00, sa, sw}, 9'h002);
        chk({8'h00, be}, 9'h000);
        @(posedge clk);
        host_i.wr(0, 9'h000);
        cyc(2);
        chk({8'h00, sa}, 9'h000);
        @(posedge clk);
        stp <= 1'h1;
        cyc(4);
        chk({8'h00, sa}, 9'h001);
        @(posedge clk);
        {stp, spl} <= 2'h1;
        cyc(4);
        chk({8'h00, sa}, 9'h000);
        @(posedge clk);
        pin_n <= 1'h1;
        rev <= 1'h1;
        host_i.wr(0, 9'h001);
        cyc(3);
        chk({8'h00, sw}, 9'h000);
        @(posedge clk);
        host_i.wr(0, 9'h000);
        cyc(3);
        chk({8'h00, sw}, 9'h001);
        // Charge parks in CV until the safety timer runs out
        @(posedge clk);
        {rev, pin_n} <= 2'h0;
        host_i.wr(10, 9'h000);
        cyc(43150);
        chk({8'h00, sf}, 9'h000);
        cyc(150);
        chk({8'h00, sf}, 9'h001);
        chk({6'h00, ph}, 9'h000);
        cyc(4);
        chk(9'(npul), 9'(nchg));
        stop_test;
    end
endmodule
